// ===== rtl/picvic_top.sv
// Purpose: latch, gate and arbitrate interrupt requests and offer a vector to the core
// Assumes: event inputs are one-cycle pulses synchronous to i_sys_clk
// Notes:   enable register is loaded through its port strobe; a request-port strobe clears the bits written as zero

`timescale 1ns/100ps

module picvic_top (
   input  wire logic                 i_sys_clk,
   input  wire logic                 i_reset,
   input  wire logic                 i_clk_en,
   input  wire picvic_pkg::picvic_hw_t i_hw_event,
   input  wire logic                 i_brk,
   input  wire logic [7:0]           i_status,
   input  wire logic [1:0]           i_wait_mode,
   input  wire logic                 i_ena_wr,
   input  wire picvic_pkg::picvic_hw_t i_ena_wdata,
   input  wire logic                 i_req_wr,
   input  wire logic [11:0]          i_req_wdata,
   input  wire logic                 i_svc_start,
   output logic                      o_irq,
   output picvic_pkg::picvic_vec_t   o_vec,
   output logic [11:0]               o_req,
   output picvic_pkg::picvic_hw_t    o_ena,
   output logic                      o_wake
);

   // ---------------------------------------------------------------
   // decode helpers
   // ---------------------------------------------------------------

   // lowest set index wins; caller checks that some bit is set
   function automatic logic [3:0] pick(input logic [11:0] p);
      logic [3:0] w;
      w = 4'h0;
      for (int i = picvic_pkg::NUM_SRC - 1; i >= 0; i--) begin
         if (p[i]) begin
            w = 4'(i);
         end
      end
      return w;
   endfunction

   function automatic logic [15:0] vec_lo(input logic [3:0] idx);
      case (idx)
         4'h0:    vec_lo = picvic_pkg::VEC_BRK;
         4'h1:    vec_lo = picvic_pkg::VEC_SPTX;
         4'h2:    vec_lo = picvic_pkg::VEC_SPRX;
         4'h3:    vec_lo = picvic_pkg::VEC_ASA;
         4'h4:    vec_lo = picvic_pkg::VEC_ASB;
         4'h5:    vec_lo = picvic_pkg::VEC_EXT;
         4'h6:    vec_lo = picvic_pkg::VEC_DAC;
         4'h7:    vec_lo = picvic_pkg::VEC_TMR0;
         4'h8:    vec_lo = picvic_pkg::VEC_TMR1;
         4'h9:    vec_lo = picvic_pkg::VEC_PTA;
         4'hA:    vec_lo = picvic_pkg::VEC_BASE;
         4'hB:    vec_lo = picvic_pkg::VEC_LCD;
         default: vec_lo = picvic_pkg::VEC_RESET;
      endcase
   endfunction

   // high byte sits at the odd address above
   function automatic picvic_pkg::picvic_vec_t mk_vec(input logic v, input logic [3:0] idx,
                                                      input logic [15:0] lo);
      mk_vec.valid = v;
      mk_vec.idx   = idx;
      mk_vec.lo    = lo;
      mk_vec.hi    = lo | 16'h0001;
   endfunction

   // ---------------------------------------------------------------
   // source gating
   // ---------------------------------------------------------------
   logic [11:0] set_vec;
   logic [11:0] ena_full;
   logic [11:0] pend;
   logic        i_flag;
   logic        can_take;
   logic [3:0]  win;

   always_comb begin
      set_vec  = {i_hw_event & o_ena, i_brk};
      // break has no enable bit of its own
      ena_full = {o_ena, 1'b1};
      // enable cleared later still masks a latched bit
      pend     = o_req & ena_full;
      i_flag   = i_status[picvic_pkg::I_FLAG_BIT];
      can_take = (pend != 12'h000) && !i_flag;
      win      = pick(pend);
   end

   // ---------------------------------------------------------------
   // offer state machine
   // ---------------------------------------------------------------
   picvic_pkg::picvic_state_t state;
   picvic_pkg::picvic_state_t next_state;
   logic                      next_irq;
   picvic_pkg::picvic_vec_t   next_vec;
   logic                      hw_clr;

   always_comb begin
      next_state = state;
      next_irq   = o_irq;
      next_vec   = o_vec;
      hw_clr     = 1'b0;
      case (state)
         picvic_pkg::PICVIC_IDLE: begin
            // pending and flag clear: present the vector
            if (can_take) begin
               next_state = picvic_pkg::PICVIC_OFFER;
               next_irq   = 1'b1;
               next_vec   = mk_vec(1'b1, win, vec_lo(win));
            end
         end
         picvic_pkg::PICVIC_OFFER: begin
            if (i_svc_start) begin
               // service start clears the served bit
               hw_clr     = 1'b1;
               next_state = picvic_pkg::PICVIC_IDLE;
               next_irq   = 1'b0;
               next_vec.valid = 1'b0;
            end else if (!can_take) begin
               // withdrawn: flag set or request cleared before service
               next_state = picvic_pkg::PICVIC_IDLE;
               next_irq   = 1'b0;
               next_vec.valid = 1'b0;
            end else begin
               // a more urgent arrival replaces the offer
               next_vec = mk_vec(1'b1, win, vec_lo(win));
            end
         end
         default: begin
            next_state = picvic_pkg::PICVIC_IDLE;
            next_irq   = 1'b0;
         end
      endcase
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         state <= picvic_pkg::PICVIC_IDLE;
         o_irq <= 1'b0;
         // reset vector shown until the first offer
         o_vec <= mk_vec(1'b0, 4'h0, picvic_pkg::VEC_RESET);
      end else if (i_clk_en) begin
         state <= next_state;
         o_irq <= next_irq;
         o_vec <= next_vec;
      end
   end

   // ---------------------------------------------------------------
   // request and enable registers
   // ---------------------------------------------------------------
   logic [11:0]            next_req;
   picvic_pkg::picvic_hw_t next_ena;
   logic                   next_wake;

   genvar g;
   generate
      for (g = 0; g < picvic_pkg::NUM_SRC; g++) begin : g_req
         logic sw_clr;
         logic svc_clr;
         always_comb begin
            sw_clr      = i_req_wr && !i_req_wdata[g];
            svc_clr     = hw_clr && (o_vec.idx == 4'(g));
            // a new event beats a clear in the same cycle
            next_req[g] = (o_req[g] && !sw_clr && !svc_clr) || set_vec[g];
         end
      end
   endgenerate

   always_comb begin
      next_ena  = i_ena_wr ? i_ena_wdata : o_ena;
      next_wake = (set_vec != 12'h000) && (i_wait_mode != 2'b00);
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         o_req  <= picvic_pkg::REQ_RST;
         o_ena  <= picvic_pkg::ENA_RST;
         o_wake <= 1'b0;
      end else if (i_clk_en) begin
         o_req  <= next_req;
         o_ena  <= next_ena;
         o_wake <= next_wake;
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   logic [11:0] below_mask;

   always_comb begin
      below_mask = (12'h001 << o_vec.idx) - 12'h001;
   end

   AST_GATE_IFLAG: assert property (@(posedge i_sys_clk) disable iff (i_reset)
      $rose(o_irq) |-> !$past(i_flag))
      else $error("offer raised while disable flag was set");

   AST_ENA_NEEDED: assert property (@(posedge i_sys_clk) disable iff (i_reset)
      $rose(o_irq) |-> (($past(ena_full) & (12'h001 << o_vec.idx)) != 12'h000))
      else $error("offered a source whose enable was clear");

   AST_LOWEST_WINS: assert property (@(posedge i_sys_clk) disable iff (i_reset)
      $rose(o_irq) |-> (($past(pend) & below_mask) == 12'h000))
      else $error("offered source is not the most urgent");

   AST_EVENT_LATCH: assert property (@(posedge i_sys_clk) disable iff (i_reset)
      (i_clk_en && set_vec != 12'h000) |=> ((o_req & $past(set_vec)) == $past(set_vec)))
      else $error("enabled event did not set its request bit");

   AST_WAKE: assert property (@(posedge i_sys_clk) disable iff (i_reset)
      (i_clk_en && set_vec != 12'h000 && i_wait_mode != 2'b00) |=> o_wake)
      else $error("no wake for event in wait mode");

   AST_OFFER_TIME: assert property (@(posedge i_sys_clk) disable iff (i_reset)
      (i_clk_en && state == picvic_pkg::PICVIC_IDLE && can_take) |=> o_irq && o_vec.valid)
      else $error("pending request not offered next cycle");

   AST_SW_CLEAR: assert property (@(posedge i_sys_clk) disable iff (i_reset)
      (i_clk_en && i_req_wr && set_vec == 12'h000)
      |=> ((o_req & ~$past(i_req_wdata)) == 12'h000))
      else $error("zero write left a request bit set");

   AST_HW_CLEAR: assert property (@(posedge i_sys_clk) disable iff (i_reset)
      (i_clk_en && o_irq && i_svc_start && !set_vec[o_vec.idx])
      |=> !o_req[$past(o_vec.idx)] && !o_irq)
      else $error("service start did not clear the request");

   AST_SET_WINS: assert property (@(posedge i_sys_clk) disable iff (i_reset)
      (i_clk_en && i_req_wr && set_vec != 12'h000)
      |=> ((o_req & $past(set_vec)) == $past(set_vec))
          && ((o_req & ~$past(i_req_wdata) & ~$past(set_vec)) == 12'h000))
      else $error("clear overrode a same-cycle event");

   AST_VEC_PAIR: assert property (@(posedge i_sys_clk) disable iff (i_reset)
      o_irq |-> (o_vec.lo[0] == 1'b0) && (o_vec.hi == o_vec.lo + 16'h0001))
      else $error("vector bytes not an even/odd pair");

   AST_RESET_VEC: assert property (@(posedge i_sys_clk)
      $past(i_reset) && !i_reset |-> o_vec.lo == picvic_pkg::VEC_RESET && !o_irq)
      else $error("reset vector not shown after reset");

endmodule

// ===== rtl/picvic_pkg.sv
// Purpose: constants and carriers of the prioritized vector interrupt controller
// Assumes: one 25 MHz clock, synchronous active-high reset
// Notes:   request index = priority number - 1, so the lowest index wins

package picvic_pkg;

   localparam int NUM_HW     = 11;
   localparam int NUM_SRC    = 12;
   localparam int I_FLAG_BIT = 2;

   localparam logic [10:0] ENA_RST = 11'h000;
   localparam logic [11:0] REQ_RST = 12'h000;

   // low-byte vector locations; the high byte sits one above
   localparam logic [15:0] VEC_RESET = 16'h7FFC;
   localparam logic [15:0] VEC_BRK   = 16'h7FFE;
   localparam logic [15:0] VEC_SPTX  = 16'h7FE8;
   localparam logic [15:0] VEC_SPRX  = 16'h7FE6;
   localparam logic [15:0] VEC_ASA   = 16'h7FE4;
   localparam logic [15:0] VEC_ASB   = 16'h7FE2;
   localparam logic [15:0] VEC_EXT   = 16'h7FF8;
   localparam logic [15:0] VEC_DAC   = 16'h7FF6;
   localparam logic [15:0] VEC_TMR0  = 16'h7FF4;
   localparam logic [15:0] VEC_TMR1  = 16'h7FF2;
   localparam logic [15:0] VEC_PTA   = 16'h7FF0;
   localparam logic [15:0] VEC_BASE  = 16'h7FEE;
   localparam logic [15:0] VEC_LCD   = 16'h7FEC;

   // first field is the msb: bit 0 is priority 2, bit 10 priority 12
   typedef struct packed {
      logic lcd_frame_irq;
      logic base_tick_irq;
      logic port_a_change_irq;
      logic timer_one_irq;
      logic timer_zero_irq;
      logic dac_reload_irq;
      logic external_edge_irq;
      logic async_serial_vec_b_irq;
      logic async_serial_vec_a_irq;
      logic serial_periph_rx_ready_irq;
      logic serial_periph_tx_empty_irq;
   } picvic_hw_t;

   typedef struct packed {
      logic        valid;
      logic [3:0]  idx;
      logic [15:0] lo;
      logic [15:0] hi;
   } picvic_vec_t;

   typedef enum logic [1:0] {
      PICVIC_IDLE  = 2'b01,
      PICVIC_OFFER = 2'b10
   } picvic_state_t;

endpackage

// ===== tb/picvic_core_model.sv
// Purpose: behavioural core that takes offered vectors and starts service
// Assumes: service strobe changes on the falling edge, held to the sampling edge
// Notes:   i_delay sets how many offered cycles pass before the core answers

`timescale 1ns/100ps

module picvic_core_model (
   input  wire logic                    i_sys_clk,
   input  wire logic                    i_irq,
   input  wire picvic_pkg::picvic_vec_t i_vec,
   input  wire logic                    i_go,
   input  wire logic [1:0]              i_delay,
   output logic                         o_svc_start,
   output picvic_pkg::picvic_vec_t      o_last,
   output int                           o_count
);
   logic [1:0] wait_cnt;

   initial begin
      o_svc_start = 1'h0;
      wait_cnt = 2'h0;
      o_count = 0;
      o_last = '0;
   end

   always @(negedge i_sys_clk) begin
      if (i_go && i_irq) begin
         if (wait_cnt >= i_delay) o_svc_start = 1'h1;
         else wait_cnt = wait_cnt + 2'h1;
      end else begin
         o_svc_start = 1'h0;
         wait_cnt = 2'h0;
      end
   end

   always @(posedge i_sys_clk) begin
      if (o_svc_start && i_irq) begin
         o_last <= i_vec;
         o_count <= o_count + 1;
      end
   end
endmodule

// ===== tb/tb_picvic_top.sv
// Purpose: self-checking bench of the interrupt controller
// Assumes: inputs change on the falling edge, outputs checked there
// Notes:   clock enable dropped once to check freezing; a stalled run is cut by a cycle ceiling

`timescale 1ns/100ps

module tb_picvic_top;
   logic                    clk = 1'h0, rst = 1'h1, brk = 1'h0, ena_wr = 1'h0, req_wr = 1'h0;
   logic                    go = 1'h0, ce = 1'h1, svc, irq, wake;
   logic [1:0]              wmode = 2'h0, dly = 2'h0;
   logic [7:0]              status = 8'h04;
   logic [10:0]             ena_d = 11'h000;
   logic [11:0]             req_d = 12'hFFF, req;
   picvic_pkg::picvic_hw_t  hw = '0, ena;
   picvic_pkg::picvic_vec_t vec, last;
   int                      cnt, err_count = 0, compares = 0, cyc = 0;
   logic [15:0]             tbl [12] = '{16'h7FFE, 16'h7FE8, 16'h7FE6, 16'h7FE4, 16'h7FE2,
      16'h7FF8, 16'h7FF6, 16'h7FF4, 16'h7FF2, 16'h7FF0, 16'h7FEE, 16'h7FEC};

   picvic_top dut (.i_sys_clk(clk), .i_reset(rst), .i_clk_en(ce), .i_hw_event(hw),
      .i_brk(brk), .i_status(status), .i_wait_mode(wmode), .i_ena_wr(ena_wr),
      .i_ena_wdata(ena_d), .i_req_wr(req_wr), .i_req_wdata(req_d), .i_svc_start(svc),
      .o_irq(irq), .o_vec(vec), .o_req(req), .o_ena(ena), .o_wake(wake));
   picvic_core_model core (.i_sys_clk(clk), .i_irq(irq), .i_vec(vec), .i_go(go),
      .i_delay(dly), .o_svc_start(svc), .o_last(last), .o_count(cnt));

   initial begin
      forever #20 clk = ~clk;
   end

   // ---------------------------------------------------------------
   // shared tasks
   // ---------------------------------------------------------------
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
      end
   endtask

   task automatic fire(input logic [11:0] m);
      @(negedge clk);
      brk = m[0];
      hw = m[11:1];
      @(negedge clk);
      brk = 1'h0;
      hw = '0;
   endtask

   task automatic wr(input logic e, input logic [11:0] d);
      @(negedge clk);
      if (e) begin
         ena_wr = 1'h1;
         ena_d = d[10:0];
      end else begin
         req_wr = 1'h1;
         req_d = d;
      end
      @(negedge clk);
      ena_wr = 1'h0;
      req_wr = 1'h0;
   endtask

   task automatic summarize;
      $display("comparisons %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_reset;
      chk({4'h0, req}, 16'h0000, "req after reset");
      chk({5'h00, ena}, 16'h0000, "ena after reset");
      chk({15'h0000, irq}, 16'h0000, "no offer after reset");
      chk({15'h0000, wake}, 16'h0000, "no wake after reset");
      chk(vec.lo, 16'h7FFC, "reset vector lo");
      chk(vec.hi, 16'h7FFD, "reset vector hi");
   endtask

   // clock enable low must drop the event of that cycle
   task automatic t_freeze;
      @(negedge clk);
      ce = 1'h0;
      fire(12'h001);
      chk({4'h0, req}, 16'h0000, "event taken while frozen");
      ce = 1'h1;
   endtask

   task automatic t_gate;
      fire(12'hFFF);
      chk({4'h0, req}, 16'h0001, "only break latched");
      chk({15'h0000, wake}, 16'h0000, "no wake while running");
      wr(1'h1, 12'h7FF);
      chk({5'h00, ena}, 16'h07FF, "enable loaded");
      fire(12'hFFE);
      chk({4'h0, req}, 16'h0FFF, "all latched");
      repeat (3) @(negedge clk);
      chk({15'h0000, irq}, 16'h0000, "offer while disabled");
      wr(1'h0, 12'h555);
      chk({4'h0, req}, 16'h0555, "zero write clears");
      wr(1'h0, 12'h000);
      chk({4'h0, req}, 16'h0000, "all cleared");
   endtask

   task automatic t_priority;
      fire(12'hFFF);
      dly = 2'h2;
      go = 1'h1;
      status = 8'h00;
      for (int i = 0; i < 12; i++) begin
         for (int n = 0; n < 20 && cnt == i; n++) @(negedge clk);
         chk({12'h000, last.idx}, 16'(i), "service order");
         chk(last.lo, tbl[i], "vector lo");
         chk(last.hi, tbl[i] + 16'h0001, "vector hi");
      end
      repeat (2) @(negedge clk);
      chk({4'h0, req}, 16'h0000, "cleared by service");
      go = 1'h0;
   endtask

   task automatic t_wake;
      wmode = 2'h1;
      fire(12'h020);
      chk({15'h0000, wake}, 16'h0001, "wake on event");
      // the offer follows the latched request by one cycle
      chk({15'h0000, irq}, 16'h0000, "offer too early");
      @(negedge clk);
      chk({15'h0000, irq}, 16'h0001, "offer with flag clear");
      chk({15'h0000, vec.valid}, 16'h0001, "offer valid");
      chk(vec.lo, 16'h7FF8, "edge vector lo");
      chk(vec.hi, 16'h7FF9, "edge vector hi");
      status = 8'h04;
      repeat (2) @(negedge clk);
      chk({15'h0000, irq}, 16'h0000, "withdrawn on disable");
      chk({15'h0000, vec.valid}, 16'h0000, "valid after withdraw");
      chk({4'h0, req}, 16'h0020, "request kept");
      wmode = 2'h2;
      fire(12'h001);
      chk({15'h0000, wake}, 16'h0001, "wake in second wait mode");
      chk({4'h0, req}, 16'h0021, "break latched while disabled");
      wr(1'h1, 12'h000);
      fire(12'h040);
      chk({15'h0000, wake}, 16'h0000, "no wake when masked");
      chk({4'h0, req}, 16'h0021, "masked not latched");
      @(negedge clk);
      brk = 1'h1;
      req_wr = 1'h1;
      req_d = 12'h000;
      @(negedge clk);
      brk = 1'h0;
      req_wr = 1'h0;
      chk({4'h0, req}, 16'h0001, "event beats same-cycle clear");
   endtask

   // ---------------------------------------------------------------
   // main sequence and timeout
   // ---------------------------------------------------------------
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         err_count++;
         summarize();
      end
   end

   initial begin
      repeat (2) @(negedge clk);
      rst = 1'h0;
      @(negedge clk);
      t_reset();
      t_freeze();
      t_gate();
      t_priority();
      t_wake();
      summarize();
   end
endmodule
